// >>> serial_cmd_pkg.sv
/*
  Shared constants for the serial command input block: frame layout, address codes,
  control field positions and converter core decode widths.
  Assumes nothing of its surroundings.
*/
package serial_cmd_pkg;
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned ADDR_BITS = 8;
  localparam int unsigned DATA_BITS = 16;
  localparam int unsigned ADDR_MSB = 23;
  localparam int unsigned ADDR_LSB = 16;
  localparam int unsigned DATA_MSB = 15;
  localparam int unsigned BIT_CNT_W = 5;
  localparam logic [4:0] BIT_CNT_FULL = 5'h18;

  localparam logic [7:0] ADDR_NOP = 8'h00;
  localparam logic [7:0] ADDR_CONVERTER_CODE = 8'h01;
  localparam logic [7:0] ADDR_READBACK = 8'h02;
  localparam logic [7:0] ADDR_OUTPUT_CONFIGURATION = 8'h55;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h56;

  localparam logic [15:0] CONVERTER_CODE_RESET = 16'h0000;
  localparam logic [15:0] OUTPUT_CONFIGURATION_RESET = 16'h0000;
  localparam logic [1:0] READ_SEL_RESET = 2'h0;

  localparam int unsigned OUTPUT_ENABLE_POS = 12;
  localparam int unsigned RANGE_LSB = 0;
  localparam int unsigned RANGE_W = 3;
  localparam int unsigned READ_SEL_W = 2;

  // Ranges 0 to 3 pick the voltage path, 4 to 6 the current path.
  localparam logic [2:0] RANGE_FIRST_CURRENT = 3'h4;
  localparam logic [2:0] RANGE_LAST_CURRENT = 3'h6;

  localparam int unsigned SEGMENT_IN_W = 4;
  localparam int unsigned SEGMENT_OUT_W = 15;
  localparam int unsigned LADDER_W_16BIT = 12;
endpackage : serial_cmd_pkg

// >>> word_link_if.sv
/*
  Carries one latched 24-bit word from the shift-clock domain to the reference clock
  domain as a toggle event with a stable data bundle.
  Assumes the sender holds the word steady from the toggle until the next toggle.
*/
`timescale 1ns/1ps
`default_nettype none
interface word_link_if;
  logic [23:0] word;
  logic toggle;
  modport sender (output word, output toggle);
  modport receiver (input word, input toggle);
endinterface : word_link_if
`default_nettype wire

// >>> word_capture.sv
/*
  Shift register on the host's shift clock. A rising latch edge, sampled on the same
  clock, snapshots the last 24 bits and flips the event toggle.
  Assumes the host runs the shift clock for a few edges after raising the latch, or
  holds it running freely; the snapshot only needs one shift-clock edge with latch high.
*/
`timescale 1ns/1ps
`default_nettype none
module word_capture
  import serial_cmd_pkg::*;
(
  input wire logic i_shift_clk,
  input wire logic i_rstn,
  input wire logic i_serial_in,
  input wire logic i_latch,
  word_link_if.sender link
);
  logic [FRAME_BITS-1:0] shift_q;
  logic [FRAME_BITS-1:0] shift_d;
  logic latch_q;
  logic [FRAME_BITS-1:0] word_q;
  logic toggle_q;
  wire latch_rise = i_latch && !latch_q;

  // Newest bit enters at bit 0, so the first bit of a word ends in bit 23.
  assign shift_d = {shift_q[FRAME_BITS-2:0], i_serial_in};

  // Shifting never looks at the latch level.
  always_ff @(posedge i_shift_clk) begin
    if (!i_rstn) begin
      shift_q <= '0;
      latch_q <= 1'b0;
      word_q <= '0;
      toggle_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      latch_q <= i_latch;
      if (latch_rise) begin
        word_q <= shift_q;
        toggle_q <= !toggle_q;
      end
    end
  end

  assign link.word = word_q;
  assign link.toggle = toggle_q;

  chk_latch_snapshot: assert property (@(posedge i_shift_clk) disable iff (!i_rstn)
    latch_rise |=> word_q == $past(shift_q)) else $error("latched word is not the shifted word");
  chk_shift_order: assert property (@(posedge i_shift_clk) disable iff (!i_rstn)
    1'b1 |=> shift_q[0] == $past(i_serial_in)) else $error("serial bit not shifted in");
endmodule : word_capture
`default_nettype wire

// >>> dac_serial_command_input.sv
/*
  Serial command input of a single-channel converter: shift-clock capture, crossing to the
  reference clock, address decode into the registers, output path select and core switch decode.
  Assumes the host keeps its shift clock at or below its rated rate and frames words correctly.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_serial_command_input
  import serial_cmd_pkg::*;
#(
  parameter int unsigned RESOLUTION = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_shift_clk,
  input wire logic i_serial_in,
  input wire logic i_latch,
  output logic [15:0] o_converter_code,
  output logic [15:0] o_output_configuration,
  output logic [1:0] o_read_select,
  output logic o_readback_armed,
  output logic o_voltage_enable,
  output logic o_current_loop_pin_enable,
  output logic [2:0] o_output_range,
  output logic [14:0] o_segment_switches,
  output logic [11:0] o_ladder_switches,
  output logic o_soft_reset_pulse
);
  import serial_cmd_pkg::*;

  localparam int unsigned LADDER_W = RESOLUTION - SEGMENT_IN_W;

  word_link_if link ();

  word_capture u_capture (
    .i_shift_clk(i_shift_clk),
    .i_rstn(i_rstn),
    .i_serial_in(i_serial_in),
    .i_latch(i_latch),
    .link(link)
  );

  // Toggle crossing: the first stage feeds only the second.
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= link.toggle;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  wire word_event = sync2_q ^ sync3_q;
  // The word bundle has been stable for at least one reference cycle here.
  wire [ADDR_BITS-1:0] addr_word = link.word[ADDR_MSB:ADDR_LSB];
  wire [DATA_BITS-1:0] data_word = link.word[DATA_MSB:0];

  wire hit_code = word_event && (addr_word == ADDR_CONVERTER_CODE);
  wire hit_readback = word_event && (addr_word == ADDR_READBACK);
  wire hit_config = word_event && (addr_word == ADDR_OUTPUT_CONFIGURATION);
  wire hit_reset = word_event && (addr_word == ADDR_SOFT_RESET);
  // A soft reset word with data bit 0 set clears the code, control, read select and armed registers to their reset values.
  wire clear_all = hit_reset && data_word[0];

  logic [15:0] code_q;
  logic [15:0] code_d;
  logic [15:0] config_q;
  logic [15:0] config_d;
  logic [1:0] read_sel_q;
  logic [1:0] read_sel_d;
  logic armed_q;
  logic armed_d;
  logic reset_pulse_q;

  // Unlisted codes fall through with the registers held; no-op words hold them too but clear the readback arm.
  assign code_d = clear_all ? CONVERTER_CODE_RESET : (hit_code ? data_word : code_q);
  assign config_d = clear_all ? OUTPUT_CONFIGURATION_RESET : (hit_config ? data_word : config_q);
  assign read_sel_d = clear_all ? READ_SEL_RESET : (hit_readback ? data_word[READ_SEL_W-1:0] : read_sel_q);
  assign armed_d = clear_all ? 1'b0 : (hit_readback ? 1'b1 : ((word_event && addr_word == ADDR_NOP) ? 1'b0 : armed_q));

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      code_q <= CONVERTER_CODE_RESET;
      config_q <= OUTPUT_CONFIGURATION_RESET;
      read_sel_q <= READ_SEL_RESET;
      armed_q <= 1'b0;
      reset_pulse_q <= 1'b0;
    end else begin
      code_q <= code_d;
      config_q <= config_d;
      read_sel_q <= read_sel_d;
      armed_q <= armed_d;
      reset_pulse_q <= clear_all;
    end
  end

  // Output path decode from control fields only; ranges 0-3 voltage, 4-6 current.
  wire out_en = config_q[OUTPUT_ENABLE_POS];
  wire [RANGE_W-1:0] range_field = config_q[RANGE_LSB +: RANGE_W];
  wire range_is_current = (range_field >= RANGE_FIRST_CURRENT) && (range_field <= RANGE_LAST_CURRENT);
  wire range_is_voltage = range_field < RANGE_FIRST_CURRENT;
  wire voltage_en_d = out_en && range_is_voltage;
  wire current_en_d = out_en && range_is_current;

  // Thermometer decode of the top four code bits.
  wire [SEGMENT_IN_W-1:0] seg_code = code_q[DATA_MSB -: SEGMENT_IN_W];
  logic [SEGMENT_OUT_W-1:0] segment_d;
  always_comb begin
    for (int i = 0; i < SEGMENT_OUT_W; i++) begin
      segment_d[i] = (32'(seg_code) > i);
    end
  end

  // Lower bits go straight to the ladder, right aligned and zero-filled at the top when RESOLUTION is below 16.
  wire [LADDER_W_16BIT-1:0] ladder_d = LADDER_W_16BIT'(code_q[DATA_MSB-SEGMENT_IN_W -: LADDER_W]);

  logic voltage_en_q;
  logic current_en_q;
  logic [SEGMENT_OUT_W-1:0] segment_q;
  logic [LADDER_W_16BIT-1:0] ladder_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      voltage_en_q <= 1'b0;
      current_en_q <= 1'b0;
      segment_q <= '0;
      ladder_q <= '0;
    end else begin
      voltage_en_q <= voltage_en_d;
      current_en_q <= current_en_d;
      segment_q <= segment_d;
      ladder_q <= ladder_d;
    end
  end

  assign o_converter_code = code_q;
  assign o_output_configuration = config_q;
  assign o_read_select = read_sel_q;
  assign o_readback_armed = armed_q;
  assign o_voltage_enable = voltage_en_q;
  assign o_current_loop_pin_enable = current_en_q;
  assign o_output_range = range_field;
  assign o_segment_switches = segment_q;
  assign o_ladder_switches = ladder_q;
  assign o_soft_reset_pulse = reset_pulse_q;

  sequence s_code_word;
    word_event && addr_word == ADDR_CONVERTER_CODE;
  endsequence
  sequence s_config_word;
    word_event && addr_word == ADDR_OUTPUT_CONFIGURATION && !clear_all;
  endsequence

  chk_exclusive_paths: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !(o_voltage_enable && o_current_loop_pin_enable)) else $error("both output paths active");
  chk_code_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_code_word |=> o_converter_code == $past(data_word)) else $error("data register not written");
  chk_config_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_config_word |=> o_output_configuration == $past(data_word)) else $error("control not written");
  chk_unlisted_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (word_event && addr_word != ADDR_CONVERTER_CODE && addr_word != ADDR_OUTPUT_CONFIGURATION
     && addr_word != ADDR_SOFT_RESET) |=> $stable(o_converter_code) && $stable(o_output_configuration))
    else $error("registers changed on unlisted word");
  chk_readback_arm: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    hit_readback |=> o_readback_armed && o_read_select == $past(data_word[1:0])) else $error("readback not armed");
  chk_path_from_config: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_config_word ##1 1'b1 |=> o_current_loop_pin_enable == current_en_d) else $error("path not from control");
  chk_thermometer: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $changed(code_q) |=> $countones(o_segment_switches) == $past(code_q[15:12])) else $error("bad segment decode");
  chk_ladder_bits: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $changed(code_q) |=> o_ladder_switches == $past(code_q[11:0])) else $error("bad ladder bits");
  chk_reset_clear: assert property (@(posedge i_ref_clk)
    !i_rstn |=> o_converter_code == '0 && o_output_configuration == '0) else $error("reset left state");
endmodule : dac_serial_command_input
`default_nettype wire

// >>> host_serial_model.sv
/*
  Host serial master that shifts command words into the converter front end.
  Assumes its caller waits long enough between frames for the reference clock side.
*/
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  output logic o_shift_clk,
  output logic o_serial_in,
  output logic o_latch
);
  initial begin
    o_shift_clk = 1'b0;
    o_serial_in = 1'b0;
    o_latch = 1'b0;
  end
  // Data and latch change only while the shift clock is low.
  task automatic tick(input logic d);
    o_serial_in = d;
    #3.0 o_shift_clk = 1'b1;
    #3.0 o_shift_clk = 1'b0;
  endtask : tick
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) tick(~o_serial_in);
  endtask : idle
  // Leading junk bits go in with the latch still high from the last frame.
  task automatic frame(input logic [23:0] word, input int pre);
    for (int i = 0; i < pre; i++) tick(1'($urandom));
    o_latch = 1'b0;
    for (int i = 23; i >= 0; i--) tick(word[i]);
    o_latch = 1'b1;
    tick(~word[0]);
    tick(word[0]);
    o_serial_in = ~word[0];
  endtask : frame
endmodule : host_serial_model
`default_nettype wire

// >>> dac_serial_command_input_test.sv
/*
  Self-checking bench for the serial command input: a host model sends words, a monitor compares outputs.
  Assumes the package constants and the settle latency stated by the design.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_serial_command_input_test;
  import serial_cmd_pkg::*;
  logic i_ref_clk, i_rstn;
  wire logic sclk, sdin, latch;
  logic [15:0] o_converter_code, o_output_configuration;
  logic [1:0] o_read_select;
  logic o_readback_armed, o_voltage_enable, o_current_loop_pin_enable, o_soft_reset_pulse;
  logic [2:0] o_output_range;
  logic [14:0] o_segment_switches;
  logic [11:0] o_ladder_switches;
  int failures = 0;
  int comparisons = 0;
  int pulses = 0;
  int exp_pulses = 0;
  logic [15:0] m_code = 16'h0000, m_cfg = 16'h0000;
  logic [1:0] m_sel = 2'h0;
  logic m_armed = 1'b0;
  logic [66:0] exp_q[$];
  event settle;
  wire logic [66:0] act = {o_converter_code, o_output_configuration, o_read_select, o_readback_armed,
    o_voltage_enable, o_current_loop_pin_enable, o_output_range, o_segment_switches, o_ladder_switches};
  host_serial_model i_host_serial_model (.o_shift_clk(sclk), .o_serial_in(sdin), .o_latch(latch));
  dac_serial_command_input i_dac_serial_command_input (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_shift_clk(sclk), .i_serial_in(sdin), .i_latch(latch), .o_converter_code(o_converter_code),
    .o_output_configuration(o_output_configuration), .o_read_select(o_read_select),
    .o_readback_armed(o_readback_armed), .o_voltage_enable(o_voltage_enable),
    .o_current_loop_pin_enable(o_current_loop_pin_enable), .o_output_range(o_output_range),
    .o_segment_switches(o_segment_switches), .o_ladder_switches(o_ladder_switches),
    .o_soft_reset_pulse(o_soft_reset_pulse));
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) if (o_soft_reset_pulse === 1'b1) pulses <= pulses + 1;
  function automatic logic [66:0] expect_of(logic [15:0] c, logic [15:0] g, logic [1:0] s, logic a);
    logic v;
    logic i;
    v = g[12] && (g[2:0] < RANGE_FIRST_CURRENT);
    i = g[12] && (g[2:0] >= RANGE_FIRST_CURRENT) && (g[2:0] <= RANGE_LAST_CURRENT);
    return {c, g, s, a, v, i, g[2:0], 15'((16'h0001 << c[15:12]) - 16'h0001), c[11:0]};
  endfunction : expect_of
  task automatic post();
    exp_q.push_back(expect_of(m_code, m_cfg, m_sel, m_armed));
    repeat (8) @(negedge i_ref_clk);
    ->settle;
  endtask : post
  task automatic send(input logic [23:0] w);
    i_host_serial_model.frame(w, $urandom_range(0, 5));
    case (w[23:16])
      ADDR_NOP: m_armed = 1'b0;
      ADDR_CONVERTER_CODE: m_code = w[15:0];
      ADDR_READBACK: begin
        m_sel = w[1:0];
        m_armed = 1'b1;
      end
      ADDR_OUTPUT_CONFIGURATION: m_cfg = w[15:0];
      ADDR_SOFT_RESET: if (w[0]) begin
        {m_code, m_cfg, m_sel, m_armed} = '0;
        exp_pulses++;
      end
      default: ;
    endcase
    post();
  endtask : send
  initial begin
    forever begin
      @(settle);
      comparisons++;
      if (act !== exp_q[0]) begin
        failures++;
        $display("[ERR] %0t outputs %h expected %h", $time, act, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  initial begin
    #200000;
    failures++;
    test_done();
  end
  initial begin
    logic [7:0] a;
    logic [15:0] d;
    i_rstn = 1'b0;
    void'($urandom(32'h94b8));
    repeat (5) @(negedge i_ref_clk);
    i_host_serial_model.idle(4);
    repeat (5) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    post();
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      send({ADDR_CONVERTER_CODE, d});
    end
    $display("test code done");
    for (int r = 0; r < 8; r++) begin
      d = (16'($urandom) & 16'heff8) | 16'(r);
      send({ADDR_OUTPUT_CONFIGURATION, d});
      send({ADDR_OUTPUT_CONFIGURATION, d | 16'h1000});
    end
    $display("test config done");
    for (int s = 0; s < 3; s++) begin
      send({ADDR_READBACK, 14'($urandom), 2'(s)});
      send({ADDR_NOP, 16'($urandom)});
    end
    $display("test readback done");
    for (int i = 0; i < 4; i++) begin
      do a = 8'($urandom); while (a inside {ADDR_NOP, ADDR_CONVERTER_CODE, ADDR_READBACK, 8'h55, 8'h56});
      send({a, 16'($urandom)});
    end
    $display("test unlisted done");
    send({ADDR_SOFT_RESET, 16'h0002});
    send({ADDR_SOFT_RESET, 16'h0001});
    @(negedge i_ref_clk);
    comparisons++;
    if (pulses !== exp_pulses) begin
      failures++;
      $display("[ERR] %0t soft reset pulses %0d expected %0d", $time, pulses, exp_pulses);
    end
    $display("test soft reset done");
    test_done();
  end
endmodule : dac_serial_command_input_test
`default_nettype wire
